// ### wwd_pkg.sv
`default_nettype none

package wwd_pkg;

  // ----------------------------------------------------------------
  // clock and trigger filter
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned T_TRIG_MIN_NS  = 200;
  localparam int unsigned TRIG_MIN_CYC   = (T_TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRIG_CNT_W     = 5;

  // ----------------------------------------------------------------
  // reset pulse length
  // ----------------------------------------------------------------
  localparam int unsigned T_NRES_NS      = 4000000;
  localparam int unsigned RESET_CYC_DEF  = T_NRES_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // oscillator timebase
  // ----------------------------------------------------------------
  localparam int unsigned OSC_W          = 16;
  localparam int unsigned R_MIN_KOHM     = 34;
  localparam int unsigned R_MAX_KOHM     = 120;
  localparam int unsigned T_OSC_MIN_NS   = 26615;
  localparam int unsigned T_OSC_MAX_NS   = 85680;
  localparam int unsigned T_FALLBACK_NS  = 39300;
  localparam logic [15:0] OSC_MIN_CYC    = 16'((T_OSC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] OSC_MAX_CYC    = 16'(T_OSC_MAX_NS / CLK_PERIOD_NS);
  localparam logic [15:0] FALLBACK_CYC   = 16'(T_FALLBACK_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // windows in oscillator periods
  // ----------------------------------------------------------------
  localparam int unsigned WIN_W          = 12;
  localparam logic [11:0] LEAD_PERIODS   = 12'hF90;
  localparam logic [11:0] CLOSED_PERIODS = 12'h20F;
  localparam logic [11:0] OPEN_PERIODS   = 12'h229;
  localparam logic [1:0]  GOOD_TRIGS     = 2'h3;

  typedef enum logic [2:0] {
    WWD_OFF,
    WWD_RESET,
    WWD_LEAD,
    WWD_CLOSED,
    WWD_OPEN,
    WWD_WAIT_TXD
  } wwd_state_t;

endpackage

`default_nettype wire

// ### wwd_window_watchdog.sv
`default_nettype none

module wwd_window_watchdog #(
  parameter int unsigned RESET_CYCLES = wwd_pkg::RESET_CYC_DEF,
  parameter int unsigned LEAD_COUNT   = wwd_pkg::LEAD_PERIODS,
  parameter int unsigned CLOSED_COUNT = wwd_pkg::CLOSED_PERIODS,
  parameter int unsigned OPEN_COUNT   = wwd_pkg::OPEN_PERIODS,
  parameter int unsigned OSC_MIN      = wwd_pkg::OSC_MIN_CYC,
  parameter int unsigned FALLBACK     = wwd_pkg::FALLBACK_CYC
) (
  input  wire logic                       clk,                  // system clock
  input  wire logic                       reset,                // power-up reset
  input  wire logic                       service_pulse_n,      // trigger pin, async
  input  wire logic                       txd_pin,              // transmit data pin, async
  input  wire logic                       mode_pin,             // high disables watchdog, async
  input  wire logic                       timebase_fault,       // resistor pin short/open, async
  input  wire logic [wwd_pkg::OSC_W-1:0]  timebase_resistor_pin, // measured period in clk cycles
  input  wire logic                       run_mode,             // normal or fail-safe mode
  input  wire logic                       sleep_mode,           // sleep or unpowered mode
  input  wire logic                       wake_sleep,           // pulse: wake from sleep
  input  wire logic                       wake_silent,          // pulse: wake from silent
  output logic                            reset_out_n,          // reset output, low active
  output logic                            failure_fallback_out  // limp-home transistor on
);
  import wwd_pkg::*;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic trig_s1_q, trig_s2_q;
  logic txd_s1_q, txd_s2_q, txd_s3_q;
  logic modep_s1_q, modep_s2_q;
  logic rfault_s1_q, rfault_s2_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      trig_s1_q   <= 1'b1;
      trig_s2_q   <= 1'b1;
      txd_s1_q    <= 1'b1;
      txd_s2_q    <= 1'b1;
      txd_s3_q    <= 1'b1;
      modep_s1_q  <= 1'b0;
      modep_s2_q  <= 1'b0;
      rfault_s1_q <= 1'b0;
      rfault_s2_q <= 1'b0;
    end else begin
      trig_s1_q   <= service_pulse_n;
      trig_s2_q   <= trig_s1_q;
      txd_s1_q    <= txd_pin;
      txd_s2_q    <= txd_s1_q;
      txd_s3_q    <= txd_s2_q;
      modep_s1_q  <= mode_pin;
      modep_s2_q  <= modep_s1_q;
      rfault_s1_q <= timebase_fault;
      rfault_s2_q <= rfault_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // trigger filter
  // ----------------------------------------------------------------
  logic [TRIG_CNT_W-1:0] low_cnt_q;
  wire  logic            trig_low   = ~trig_s2_q;
  wire  logic            trig_valid = trig_low && (low_cnt_q == TRIG_CNT_W'(TRIG_MIN_CYC - 1));
  wire  logic            txd_fall   = txd_s3_q & ~txd_s2_q;

  // count saturates so one low phase yields one service pulse
  always_ff @(posedge clk) begin
    if (reset || !trig_low) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != TRIG_CNT_W'(TRIG_MIN_CYC)) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // oscillator timebase
  // ----------------------------------------------------------------
  wire logic             period_bad = rfault_s2_q ||
                                      (timebase_resistor_pin < OSC_W'(OSC_MIN)) ||
                                      (timebase_resistor_pin > OSC_MAX_CYC);
  wire logic [OSC_W-1:0] osc_period = period_bad ? OSC_W'(FALLBACK) : timebase_resistor_pin;
  logic      [OSC_W-1:0] div_q;
  wire logic             osc_tick   = (div_q >= osc_period - 1'b1);
  logic                  phase_start;

  always_ff @(posedge clk) begin
    if (reset || phase_start || osc_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // window and reset counters
  // ----------------------------------------------------------------
  localparam int unsigned RST_W = $clog2(RESET_CYCLES + 1);

  wwd_state_t        st_q, st_d;
  logic [WIN_W-1:0]  win_cnt_q;
  logic [RST_W-1:0]  rst_cnt_q;

  wire logic lead_done   = osc_tick && (win_cnt_q == WIN_W'(LEAD_COUNT - 1));
  wire logic closed_done = osc_tick && (win_cnt_q == WIN_W'(CLOSED_COUNT - 1));
  wire logic open_done   = osc_tick && (win_cnt_q == WIN_W'(OPEN_COUNT - 1));
  wire logic rst_done    = (rst_cnt_q == RST_W'(RESET_CYCLES - 1));
  wire logic wd_enable   = run_mode && !modep_s2_q;

  always_ff @(posedge clk) begin
    if (reset || phase_start) begin
      win_cnt_q <= '0;
    end else if (osc_tick) begin
      win_cnt_q <= win_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || st_q != WWD_RESET) begin
      rst_cnt_q <= '0;
    end else if (!rst_done) begin
      rst_cnt_q <= rst_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // wake origin
  // ----------------------------------------------------------------
  logic sleep_pend_q, silent_pend_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      sleep_pend_q  <= 1'b0;
      silent_pend_q <= 1'b0;
    end else if (wake_sleep || wake_silent) begin
      sleep_pend_q  <= wake_sleep;
      silent_pend_q <= wake_silent && !wake_sleep;
    end else if (wd_enable) begin
      sleep_pend_q  <= 1'b0;
      silent_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------
  logic fault, good_trig;

  always_comb begin
    st_d        = st_q;
    fault       = 1'b0;
    good_trig   = 1'b0;
    phase_start = 1'b0;
    if (!wd_enable) begin
      st_d = WWD_OFF;
    end else begin
      unique case (st_q)
        WWD_OFF: begin
          phase_start = 1'b1;
          if (sleep_pend_q || wake_sleep) begin
            st_d = WWD_RESET;
          end else if (silent_pend_q || wake_silent) begin
            st_d = WWD_WAIT_TXD;
          end else begin
            st_d = WWD_LEAD;
          end
        end
        WWD_RESET: begin
          if (rst_done) begin
            st_d        = WWD_LEAD;
            phase_start = 1'b1;
          end
        end
        WWD_WAIT_TXD: begin
          if (txd_fall) begin
            st_d        = WWD_LEAD;
            phase_start = 1'b1;
          end
        end
        WWD_LEAD: begin
          if (trig_valid) begin
            st_d        = WWD_CLOSED;
            phase_start = 1'b1;
          end else if (lead_done) begin
            fault = 1'b1;
          end
        end
        WWD_CLOSED: begin
          if (trig_valid) begin
            fault = 1'b1;
          end else if (closed_done) begin
            st_d        = WWD_OPEN;
            phase_start = 1'b1;
          end
        end
        WWD_OPEN: begin
          if (trig_valid) begin
            st_d        = WWD_CLOSED;
            good_trig   = 1'b1;
            phase_start = 1'b1;
          end else if (open_done) begin
            fault = 1'b1;
          end
        end
      endcase
      if (fault) begin
        st_d        = WWD_RESET;
        phase_start = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= WWD_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // reset output and limp-home
  // ----------------------------------------------------------------
  logic [1:0] good_q;
  wire  logic limp_clear = sleep_mode || modep_s2_q || wake_sleep;
  wire  logic good_last  = good_trig && (good_q == GOOD_TRIGS - 2'h1);

  always_ff @(posedge clk) begin
    if (reset) begin
      reset_out_n <= 1'b0;
    end else begin
      reset_out_n <= (st_d != WWD_RESET);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      failure_fallback_out <= 1'b0;
      good_q               <= '0;
    end else if (limp_clear) begin
      failure_fallback_out <= 1'b0;
      good_q               <= '0;
    end else if (wd_enable) begin
      if (fault) begin
        failure_fallback_out <= 1'b1;
        good_q               <= '0;
      end else if (good_last) begin
        failure_fallback_out <= 1'b0;
        good_q               <= '0;
      end else if (good_trig) begin
        good_q <= good_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  int unsigned low_run_q;

  always_ff @(posedge clk) begin
    if (reset || reset_out_n) begin
      low_run_q <= 0;
    end else begin
      low_run_q <= low_run_q + 1;
    end
  end

  sequence s_fault_out;
    !reset_out_n && failure_fallback_out && st_q == WWD_RESET;
  endsequence

  sequence s_new_closed;
    st_q == WWD_CLOSED && win_cnt_q == '0 && div_q == '0;
  endsequence

  a_glitch_filter: assert property (trig_valid |-> $past(trig_low, 19))
    else $error("trigger accepted after too short a low");

  a_lead_expire: assert property (
    st_q == WWD_LEAD && lead_done && !trig_valid && wd_enable && !limp_clear |=> s_fault_out)
    else $error("lead expiry did not raise reset and limp-home");

  a_closed_early: assert property (
    st_q == WWD_CLOSED && trig_valid && wd_enable && !limp_clear |=> s_fault_out)
    else $error("early trigger not punished");

  a_open_expire: assert property (
    st_q == WWD_OPEN && open_done && !trig_valid && wd_enable && !limp_clear |=> s_fault_out)
    else $error("open window expiry not punished");

  a_open_restart: assert property (
    st_q == WWD_OPEN && trig_valid && wd_enable |=> s_new_closed)
    else $error("open window trigger did not restart closed window");

  a_lead_trigger: assert property (
    st_q == WWD_LEAD && trig_valid && wd_enable |=> s_new_closed)
    else $error("lead trigger did not start closed window");

  a_reset_length: assert property (
    $rose(reset_out_n) && $past(wd_enable) |-> low_run_q == RESET_CYCLES)
    else $error("reset pulse length wrong");

  a_stop_idle: assert property (!wd_enable |=> st_q == WWD_OFF && reset_out_n)
    else $error("watchdog running while stopped");

  a_limp_hold: assert property (!wd_enable && !limp_clear |=> $stable(failure_fallback_out))
    else $error("limp-home changed while held");

  a_limp_disable: assert property (limp_clear |=> !failure_fallback_out)
    else $error("limp-home not disabled");

  a_limp_release: assert property (
    $fell(failure_fallback_out) && !$past(limp_clear) |-> $past(good_q) == 2'h2 && $past(good_trig))
    else $error("limp-home released without three good triggers");

  a_txd_start: assert property (
    st_q == WWD_WAIT_TXD && txd_fall && wd_enable |=> st_q == WWD_LEAD && win_cnt_q == '0)
    else $error("transmit fall did not start lead");

  a_fallback_osc: assert property (rfault_s2_q |-> osc_period == OSC_W'(FALLBACK))
    else $error("fallback oscillator not selected");

  a_whole_period: assert property (osc_tick && !phase_start |=> div_q == '0 ##0 $changed(win_cnt_q))
    else $error("window counter missed an oscillator period");

endmodule // wwd_window_watchdog

`default_nettype wire

// ### wwd_mcu_model.sv
`default_nettype none

// ----------------------------------------------------------------
// controller side: one trigger low pulse per request
// ----------------------------------------------------------------
module wwd_mcu_model (
  input  wire logic       clk,             // bench clock
  input  wire logic       fire,            // start one trigger pulse
  input  wire logic [7:0] low_len,         // low phase in clock cycles
  output logic            service_pulse_n  // trigger line to device
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] left_q = 8'h00;

  always @(posedge clk) begin
    if (fire) begin
      left_q <= low_len;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  // line idles high, falls once per request, low for low_len cycles
  assign service_pulse_n = (left_q == 8'h00);
endmodule  // wwd_mcu_model

`default_nettype wire

// ### wwd_tb.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import wwd_pkg::*;

  localparam int unsigned RC       = 200;
  localparam int unsigned OSC_N    = 8;
  localparam int unsigned LEAD_N   = 64;
  localparam int unsigned CLOSED_N = 16;
  localparam int unsigned OPEN_N   = 16;

  logic             clk         = 1'b0;
  logic             reset       = 1'b1;
  logic             txd_pin     = 1'b1;
  logic             mode_pin    = 1'b0;
  logic             tb_fault    = 1'b0;
  logic             run_mode    = 1'b1;
  logic             sleep_mode  = 1'b0;
  logic             wake_sleep  = 1'b0;
  logic             wake_silent = 1'b0;
  logic             fire        = 1'b0;
  logic [7:0]       low_len     = 8'h00;
  logic [OSC_W-1:0] osc_cyc     = 16'h0008;
  logic             svc_n;
  logic             rst_n;
  logic             limp;
  int               n_fail      = 0;
  int               checked     = 0;

  always #5 clk = ~clk;

  wwd_mcu_model mcu_u (
    .clk             (clk),
    .fire            (fire),
    .low_len         (low_len),
    .service_pulse_n (svc_n)
  );

  wwd_window_watchdog #(
    .RESET_CYCLES (RC),
    .LEAD_COUNT   (LEAD_N),
    .CLOSED_COUNT (CLOSED_N),
    .OPEN_COUNT   (OPEN_N),
    .OSC_MIN      (4),
    .FALLBACK     (12)
  ) dut_u (
    .clk                   (clk),
    .reset                 (reset),
    .service_pulse_n       (svc_n),
    .txd_pin               (txd_pin),
    .mode_pin              (mode_pin),
    .timebase_fault        (tb_fault),
    .timebase_resistor_pin (osc_cyc),
    .run_mode              (run_mode),
    .sleep_mode            (sleep_mode),
    .wake_sleep            (wake_sleep),
    .wake_silent           (wake_silent),
    .reset_out_n           (rst_n),
    .failure_fallback_out  (limp)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one pulse, then watch for a reset pulse of exact length
  task automatic trig(input logic [7:0] len, input logic exp_fault, input string name);
    int lows;
    int k;
    lows = 0;
    @(posedge clk);
    fire <= 1'b1;
    low_len <= len;
    @(posedge clk);
    fire <= 1'b0;
    for (k = 0; k < int'(len) + 12 + (exp_fault ? RC + 40 : 0); k++) begin
      @(posedge clk);
      #1;
      if (rst_n === 1'b0) lows++;
    end
    check(name, 32'(lows != 0), 32'(exp_fault));
    if (exp_fault) check("reset_len", lows, RC);
  endtask

  task automatic start_pulse(input string name);
    int lows;
    lows = 0;
    #1;
    if (rst_n === 1'b0) lows++;
    repeat (RC + 20) begin
      @(posedge clk);
      #1;
      if (rst_n === 1'b0) lows++;
    end
    check(name, lows, RC);
    check("start_rel", rst_n, 1'b1);
    check("start_limp", limp, 1'b0);
  endtask

  // no service: exactly one reset pulse inside span, limp-home on
  task automatic expire(input int span, input string name);
    int lows;
    lows = 0;
    repeat (span) begin
      @(posedge clk);
      #1;
      if (rst_n === 1'b0) lows++;
    end
    check(name, lows, RC);
    check("expire_limp", limp, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_closed_fault;
    trig(8'h0F, 1'b0, "glitch_lead");
    trig(8'h1E, 1'b0, "lead_trig");
    trig(8'h0F, 1'b0, "glitch_closed");
    trig(8'h1E, 1'b1, "early_trig");
    check("limp_on", limp, 1'b1);
  endtask

  // service period 144 cycles: past closed 128, before closed plus open 256
  task automatic t_open;
    trig(8'h1E, 1'b0, "lead_again");
    tick(100);
    trig(8'h1E, 1'b0, "open_trig_a");
    check("limp_held_a", limp, 1'b1);
    tick(100);
    trig(8'h1E, 1'b0, "open_trig_b");
    check("limp_held_b", limp, 1'b1);
    tick(100);
    trig(8'h1E, 1'b0, "open_trig_c");
    check("limp_off", limp, 1'b0);
    expire(2 * CLOSED_N * OSC_N + RC + 24, "open_expire");
    expire(LEAD_N * OSC_N + RC + 8, "lead_expire");
  endtask

  task automatic t_silent;
    @(posedge clk) run_mode <= 1'b0;
    tick(5);
    check("silent_rst", rst_n, 1'b1);
    check("silent_limp", limp, 1'b1);
    trig(8'h1E, 1'b0, "silent_trig");
    @(posedge clk) begin
      wake_silent <= 1'b1;
      run_mode <= 1'b1;
    end
    @(posedge clk) wake_silent <= 1'b0;
    trig(8'h1E, 1'b0, "pre_txd_a");
    trig(8'h1E, 1'b0, "pre_txd_b");
    @(posedge clk) begin
      txd_pin <= 1'b0;
      tb_fault <= 1'b1;
    end
    tick(5);
    trig(8'h1E, 1'b0, "txd_lead");
    trig(8'h1E, 1'b1, "txd_fault");
    check("fallback_limp", limp, 1'b1);
  endtask

  task automatic t_mode_sleep;
    @(posedge clk) mode_pin <= 1'b1;
    tick(5);
    check("mode_limp", limp, 1'b0);
    trig(8'h1E, 1'b0, "mode_off_a");
    trig(8'h1E, 1'b0, "mode_off_b");
    @(posedge clk) mode_pin <= 1'b0;
    tick(5);
    trig(8'h1E, 1'b0, "mode_lead");
    trig(8'h1E, 1'b1, "mode_fault");
    check("mode_limp_on", limp, 1'b1);
    @(posedge clk) begin
      run_mode <= 1'b0;
      sleep_mode <= 1'b1;
    end
    tick(5);
    check("sleep_limp", limp, 1'b0);
    @(posedge clk) begin
      sleep_mode <= 1'b0;
      wake_sleep <= 1'b1;
      run_mode <= 1'b1;
    end
    @(posedge clk) wake_sleep <= 1'b0;
    start_pulse("wake_pulse");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    #1;
    check("por_rst", rst_n, 1'b0);
    check("por_limp", limp, 1'b0);
    start_pulse("por_pulse");
    t_closed_fault();
    t_open();
    t_silent();
    t_mode_sleep();
    summarize();
  end

  initial begin
    #500000;
    n_fail++;
    summarize();
  end
endmodule  // testbench

`default_nettype wire
